// >>> fifo_flag_offset_serial_loader_bench.sv
`timescale 1ns/1ps
module fifo_flag_offset_serial_loader_bench;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic        master_reset = 1'h0;
    logic        serial_method_strap = 1'h1;
    logic        x9_to_x9_mode = 1'h1;
    logic        run = 1'h0;
    logic [3:0]  idle = 4'hF;
    logic [33:0] word = 34'h0;
    logic [3:0]  pins;
    logic        serial_in;
    logic [16:0] empty_offset_q;
    logic [16:0] full_offset_q;
    logic        serial_method_q, mem_write_q, mem_read_q, offset_read_q, shift_done_q;
    logic        almost_empty_valid_q, almost_full_valid_q;
    int          mismatches = 0;
    int          total_checks = 0;
    always #50 clk = ~clk;
    fosl_host fosl_host_i
    (
        .clk(clk), .srst(srst), .master_reset(master_reset), .run(run),
        .idle(idle), .word(word), .pins(pins), .serial_in(serial_in)
    );
    fosl_serial_loader fosl_serial_loader_i
    (
        .clk(clk), .srst(srst), .master_reset(master_reset),
        .serial_method_strap(serial_method_strap), .x9_to_x9_mode(x9_to_x9_mode),
        .first_word_fall_through_mode(x9_to_x9_mode),
        .offset_access_strobe_n(pins[3]), .shift_program_enable_n(pins[2]),
        .write_enable_n(pins[1]), .read_enable_n(pins[0]), .serial_in(serial_in),
        .empty_offset_q(empty_offset_q), .full_offset_q(full_offset_q),
        .serial_method_q(serial_method_q), .mem_write_q(mem_write_q),
        .mem_read_q(mem_read_q), .offset_read_q(offset_read_q),
        .shift_done_q(shift_done_q), .almost_empty_valid_q(almost_empty_valid_q),
        .almost_full_valid_q(almost_full_valid_q)
    );
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic restart(input logic strap, input logic x9);
        @(posedge clk);
        master_reset        <= 1'h1;
        serial_method_strap <= strap;
        x9_to_x9_mode       <= x9;
        @(posedge clk);
        master_reset <= 1'h0;
    endtask
    // Pause mid-load with two refused bits and a memory write to prove resume
    task automatic t_load(input logic [33:0] w, input int n);
        logic [33:0] m;
        m = (34'h1 << (n / 2)) - 34'h1;
        @(posedge clk);
        word <= w;
        run  <= 1'h1;
        repeat (5) @(posedge clk);
        run  <= 1'h0;
        idle <= 4'h7;
        repeat (2) @(posedge clk);
        idle <= 4'hD;
        @(posedge clk);
        idle <= 4'hF;
        run  <= 1'h1;
        repeat (n - 5) @(posedge clk);
        run <= 1'h0;
        @(negedge clk);
        check(shift_done_q, 1'h0);
        @(negedge clk);
        check(shift_done_q, 1'h1);
        check(almost_full_valid_q | almost_empty_valid_q, 1'h0);
        check(empty_offset_q, 17'(w & m));
        check(full_offset_q, 17'((w >> (n / 2)) & m));
        @(negedge clk);
        check(shift_done_q, 1'h0);
        @(negedge clk);
        check(almost_empty_valid_q & almost_full_valid_q, 1'h1);
    endtask
    task automatic t_ops;
        logic [3:0] c [5] = '{4'hD, 4'hE, 4'h6, 4'hB, 4'hC};
        logic [2:0] e [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            idle <= c[i];
            repeat (2) @(posedge clk);
            idle <= 4'hF;
            @(negedge clk);
            check(17'({mem_write_q, mem_read_q, offset_read_q}), 17'(e[i]));
        end
    endtask
    task automatic t_parallel;
        restart(1'h0, 1'h1);
        serial_method_strap <= 1'h1;
        run <= 1'h1;
        repeat (20) @(posedge clk);
        run <= 1'h0;
        repeat (3) @(negedge clk);
        check(empty_offset_q, 17'h0007F);
        check(full_offset_q, 17'h0007F);
        check(almost_full_valid_q, 1'h1);
        check(serial_method_q, 1'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        t_load(34'h9A5C3, 20);
        t_ops;
        restart(1'h1, 1'h0);
        t_load(34'h2B4E9, 18);
        t_parallel;
        final_report;
    end
    initial
    begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule // fifo_flag_offset_serial_loader_bench

// >>> fosl_asserts.sv
`timescale 1ns/1ps
module fosl_chk (
    input wire        clk,
    input wire        srst,
    input wire        master_reset,
    input wire        offset_access_strobe_n,
    input wire        shift_program_enable_n,
    input wire        write_enable_n,
    input wire        read_enable_n,
    input wire        serial_in,
    input wire [16:0] empty_offset_q,
    input wire [16:0] full_offset_q,
    input wire        serial_method_q,
    input wire        mem_write_q,
    input wire        mem_read_q,
    input wire        offset_read_q,
    input wire        shift_done_q,
    input wire        almost_empty_valid_q,
    input wire        almost_full_valid_q
);
    wire ld = offset_access_strobe_n;
    wire we = write_enable_n;
    wire re = read_enable_n;
    wire sh = !ld && !shift_program_enable_n && we && re && serial_method_q;
    wire av = almost_empty_valid_q && almost_full_valid_q;
    default clocking @(posedge clk); endclocking
    default disable iff (srst || master_reset);
    property p_hold; !sh |=> $stable({empty_offset_q, full_offset_q}); endproperty
    a_hold: assert property (p_hold) else $error("offset moved");
    property p_inv; sh |=> !almost_empty_valid_q && !almost_full_valid_q; endproperty
    a_inv: assert property (p_inv) else $error("flag valid in load");
    property p_val; shift_done_q && !sh ##1 !sh |=> av; endproperty
    a_val: assert property (p_val) else $error("flag late");
    property p_lsb; sh && av |=> empty_offset_q[0] == $past(serial_in); endproperty
    a_lsb: assert property (p_lsb) else $error("first bit");
    property p_wr; ld && !we |=> mem_write_q; endproperty
    a_wr: assert property (p_wr) else $error("no write");
    property p_rd; ld && !re |=> mem_read_q; endproperty
    a_rd: assert property (p_rd) else $error("no read");
    property p_ord; !ld && we && !re |=> offset_read_q; endproperty
    a_ord: assert property (p_ord) else $error("no offset read");
    property p_meth; 1'h1 |=> $stable(serial_method_q); endproperty
    a_meth: assert property (p_meth) else $error("method moved");
    cover property (shift_done_q);
    cover property (mem_write_q);
    cover property (offset_read_q);
    cover property (mem_write_q && mem_read_q);
endmodule // fosl_chk
bind fosl_serial_loader fosl_chk fosl_chk_i (
    .clk(clk), .srst(srst), .master_reset(master_reset),
    .offset_access_strobe_n(offset_access_strobe_n),
    .shift_program_enable_n(shift_program_enable_n),
    .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .serial_in(serial_in), .empty_offset_q(empty_offset_q),
    .full_offset_q(full_offset_q), .serial_method_q(serial_method_q),
    .mem_write_q(mem_write_q), .mem_read_q(mem_read_q),
    .offset_read_q(offset_read_q), .shift_done_q(shift_done_q),
    .almost_empty_valid_q(almost_empty_valid_q),
    .almost_full_valid_q(almost_full_valid_q)
);

// >>> fosl_host.sv
`timescale 1ns/1ps
module fosl_host (
    input  wire        clk,
    input  wire        srst,
    input  wire        master_reset,
    input  wire        run,
    input  wire [3:0]  idle,
    input  wire [33:0] word,
    output reg  [3:0]  pins = 4'hF,
    output reg         serial_in = 1'h0
);
    reg [5:0] n_q = 6'h00;
    // Toggling line while idle so a refused bit cannot pass for a kept one
    always @(posedge clk)
    begin
        n_q       <= (srst | master_reset) ? 6'h00 : n_q + {5'h00, run};
        pins      <= run ? 4'h3 : idle;
        serial_in <= run ? word[n_q] : ~serial_in;
    end
endmodule // fosl_host

// >>> fosl_regs.vh
`ifndef FOSL_REGS_VH
`define FOSL_REGS_VH

// Offset bits for the smallest depth in x9-to-x9 mode
`define FOSL_BASE_BITS_X9     6'd20
// Bits dropped when either port is x18
`define FOSL_X18_SHORTEN      6'd2
// Extra bits per doubling of depth
`define FOSL_BITS_PER_DOUBLE  6'd2
// Flag valid delay after the completing edge, in clock edges
`define FOSL_VALID_DELAY      2
// Offset register reset values
`define FOSL_EMPTY_RST        17'h0007F
`define FOSL_FULL_RST         17'h0007F
// Operation codes
`define FOSL_OP_NONE          2'h0
`define FOSL_OP_WRITE         2'h1
`define FOSL_OP_READ          2'h2
`define FOSL_OP_SHIFT         2'h3

`endif

// >>> fosl_serial_loader.v
`timescale 1ns/1ps
`include "fosl_regs.vh"
module fosl_serial_loader
#(
    parameter DEPTH_LOG = 0,
    parameter OFS_W     = 17
)
(
    clk,
    srst,
    master_reset,
    serial_method_strap,
    x9_to_x9_mode,
    first_word_fall_through_mode,
    offset_access_strobe_n,
    shift_program_enable_n,
    write_enable_n,
    read_enable_n,
    serial_in,
    empty_offset_q,
    full_offset_q,
    serial_method_q,
    mem_write_q,
    mem_read_q,
    offset_read_q,
    shift_done_q,
    almost_empty_valid_q,
    almost_full_valid_q
);
    input  wire             clk;
    input  wire             srst;
    input  wire             master_reset;
    input  wire             serial_method_strap;
    input  wire             x9_to_x9_mode;
    input  wire             first_word_fall_through_mode;
    input  wire             offset_access_strobe_n;
    input  wire             shift_program_enable_n;
    input  wire             write_enable_n;
    input  wire             read_enable_n;
    input  wire             serial_in;
    output reg  [OFS_W-1:0] empty_offset_q;
    output reg  [OFS_W-1:0] full_offset_q;
    output reg              serial_method_q;
    output reg              mem_write_q;
    output reg              mem_read_q;
    output reg              offset_read_q;
    output reg              shift_done_q;
    output wire             almost_empty_valid_q;
    output wire             almost_full_valid_q;

    reg  [5:0]       pos_q;
    reg  [5:0]       pos_d;
    reg  [1:0]       op;
    reg              shift_ok;
    reg              read_hit;
    reg              serial_method_d;
    reg              mem_write_d;
    reg              mem_read_d;
    reg              offset_read_d;
    reg              shift_done_d;
    wire [OFS_W-1:0] empty_offset_d;
    wire [OFS_W-1:0] full_offset_d;
    wire [OFS_W-1:0] empty_bit_hit;
    wire [OFS_W-1:0] full_bit_hit;
    wire [31:0]      depth_log_ext;
    wire [5:0]       total_bits;
    wire [5:0]       half_bits;
    wire [5:0]       final_pos;
    wire [5:0]       full_pos;
    wire             last_bit;
    wire             restart;
    wire             bit_shift;
    wire             bit_done;

    // Mode input has no effect here; the same sequence in both timing modes
    wire unused_first_word_fall_through_mode = first_word_fall_through_mode;

    assign depth_log_ext = DEPTH_LOG;
    assign total_bits = `FOSL_BASE_BITS_X9
                      + `FOSL_BITS_PER_DOUBLE * depth_log_ext[5:0]
                      - (x9_to_x9_mode ? 6'd0 : `FOSL_X18_SHORTEN);
    assign half_bits  = {1'b0, total_bits[5:1]};
    assign final_pos  = total_bits - 6'd1;
    assign full_pos   = pos_q - half_bits;
    // Also ends a load left past the end if the width input moves
    assign last_bit   = (pos_q >= final_pos);
    assign restart    = srst | master_reset;
    assign bit_shift  = shift_ok && !last_bit;
    assign bit_done   = shift_ok && last_bit;

    // Each stream position owns exactly one offset bit
    genvar gi;
    generate
        for (gi = 0; gi < OFS_W; gi = gi + 1)
        begin : g_offset_bit
            assign empty_bit_hit[gi]  = shift_ok && (pos_q < half_bits)
                                        && ({26'h0, pos_q} == gi);
            assign full_bit_hit[gi]   = shift_ok && (pos_q >= half_bits)
                                        && ({26'h0, full_pos} == gi);
            assign empty_offset_d[gi] = empty_bit_hit[gi] ? serial_in
                                                          : empty_offset_q[gi];
            assign full_offset_d[gi]  = full_bit_hit[gi] ? serial_in
                                                         : full_offset_q[gi];
        end
    endgenerate

    always @*
    begin
        op       = `FOSL_OP_NONE;
        read_hit = 1'b0;
        shift_ok = 1'b0;
        // Order: strobe, serial enable, write enable, read enable
        case ({offset_access_strobe_n, shift_program_enable_n,
               write_enable_n, read_enable_n})
            4'h3:
                op = `FOSL_OP_SHIFT;
            // Read side has its own clock, so a write must not hide it
            4'h8, 4'hC:
            begin
                op       = `FOSL_OP_WRITE;
                read_hit = 1'b1;
            end
            4'h9, 4'hD:
                op = `FOSL_OP_WRITE;
            4'hA, 4'hE:
            begin
                op       = `FOSL_OP_READ;
                read_hit = 1'b1;
            end
            // Strobe low with serial enable high never shifts
            4'h7:
                op = `FOSL_OP_NONE;
            default:
                op = `FOSL_OP_NONE;
        endcase
        shift_ok = (op == `FOSL_OP_SHIFT) && serial_method_q;
    end

    always @*
    begin
        pos_d = pos_q;
        if (shift_ok)
            pos_d = last_bit ? 6'd0 : pos_q + 6'd1;
    end

    // Method is taken only while a reset is applied
    always @*
    begin
        serial_method_d = serial_method_q;
        if (restart)
            serial_method_d = serial_method_strap;
    end

    always @(posedge clk)
    begin
        serial_method_q <= serial_method_d;
    end

    always @*
    begin
        mem_write_d   = (op == `FOSL_OP_WRITE);
        mem_read_d    = read_hit;
        // Parallel read path only; nothing shifts out
        offset_read_d = !offset_access_strobe_n && write_enable_n
                        && !read_enable_n;
        shift_done_d  = bit_done;
    end

    always @(posedge clk)
    begin
        if (restart)
        begin
            pos_q          <= 6'd0;
            empty_offset_q <= `FOSL_EMPTY_RST;
            full_offset_q  <= `FOSL_FULL_RST;
            shift_done_q   <= 1'b0;
            mem_write_q    <= 1'b0;
            mem_read_q     <= 1'b0;
            offset_read_q  <= 1'b0;
        end
        else
        begin
            pos_q          <= pos_d;
            // Empty offset LSB first, full offset MSB last
            empty_offset_q <= empty_offset_d;
            full_offset_q  <= full_offset_d;
            shift_done_q   <= shift_done_d;
            mem_write_q    <= mem_write_d;
            mem_read_q     <= mem_read_d;
            offset_read_q  <= offset_read_d;
        end
    end

    // Single clock here stands for both write and read sides
    fosl_valid_delay #(.DELAY(`FOSL_VALID_DELAY)) u_full_valid
    (
        .clk        (clk),
        .srst       (restart),
        .invalidate (bit_shift),
        .complete   (bit_done),
        .valid_q    (almost_full_valid_q)
    );

    fosl_valid_delay #(.DELAY(`FOSL_VALID_DELAY)) u_empty_valid
    (
        .clk        (clk),
        .srst       (restart),
        .invalidate (bit_shift),
        .complete   (bit_done),
        .valid_q    (almost_empty_valid_q)
    );
endmodule // fosl_serial_loader

// >>> fosl_valid_delay.v
`timescale 1ns/1ps
// Flag validity delay: output rises DELAY edges after a completion pulse
module fosl_valid_delay
#(
    parameter DELAY = 2
)
(
    clk,
    srst,
    invalidate,
    complete,
    valid_q
);
    input  wire clk;
    input  wire srst;
    input  wire invalidate;
    input  wire complete;
    output reg  valid_q;

    reg [DELAY-1:0] pipe_q;

    always @(posedge clk)
    begin
        if (srst)
        begin
            pipe_q  <= {DELAY{1'b0}};
            valid_q <= 1'b1;
        end
        else if (invalidate)
        begin
            pipe_q  <= {DELAY{1'b0}};
            valid_q <= 1'b0;
        end
        else
        begin
            pipe_q <= {pipe_q[DELAY-2:0], complete};
            if (pipe_q[DELAY-1])
                valid_q <= 1'b1;
        end
    end
endmodule // fosl_valid_delay
